// ### logic/vref_dac_pkg.sv
// package: register map, field positions, reset values and timing for the reference and ladder control
package vref_dac_pkg;
  // register addresses (word index on the plain register port)
  localparam logic [2:0] ADDR_REF_CTRL    = 3'h0; // fixed_ref_control
  localparam logic [2:0] ADDR_SRC_CTRL    = 3'h1; // dac_source_control
  localparam logic [2:0] ADDR_LEVEL_SEL   = 3'h2; // dac_level_select
  localparam logic [2:0] ADDR_IRQ_STATUS  = 3'h3; // sticky event bits, write one to clear
  localparam logic [2:0] ADDR_IRQ_MASK    = 3'h4; // interrupt mask, same layout
  localparam logic [2:0] ADDR_ADC_CFG     = 3'h5; // adc-side state seen by the buffer enable
  // fixed_ref_control fields
  localparam int REF_EN_BIT    = 7;
  localparam int REF_READY_BIT = 6;
  localparam int GAIN_HI       = 5;
  localparam int GAIN_LO       = 4;
  localparam logic [7:0] REF_CTRL_RESET = 8'h10; // gain field resets to unity
  // dac_source_control fields
  localparam int CONV_EN_BIT   = 7;
  localparam int LOW_PWR_BIT   = 6;
  localparam int PIN_OE_BIT    = 5;
  localparam int POS_SRC_HI    = 3;
  localparam int POS_SRC_LO    = 2;
  localparam int NEG_SRC_BIT   = 0;
  localparam logic [7:0] SRC_CTRL_WMASK = 8'hed; // bits 4 and 1 unimplemented
  // dac_level_select fields
  localparam int LEVEL_W       = 5;
  localparam logic [7:0] LEVEL_WMASK = 8'h1f;
  // adc config layout: bit 7 adc_on, bits 6:5 positive ref config, bits 4:0 channel
  localparam int ADC_ON_BIT    = 7;
  localparam int PVCFG_HI      = 6;
  localparam int PVCFG_LO      = 5;
  localparam logic [1:0] PVCFG_FIXED_REF = 2'h2;
  localparam logic [4:0] CHAN_FIXED_REF  = 5'h1f;
  // interrupt bits
  localparam int IRQ_READY_BIT = 0; // reference became ready
  localparam int IRQ_LOST_BIT  = 1; // reference disabled after ready
  localparam int IRQ_W         = 2;
  // gain codes
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_X1  = 2'h1;
  localparam logic [1:0] GAIN_X2  = 2'h2;
  localparam logic [1:0] GAIN_X4  = 2'h3;
  // positive source codes
  localparam logic [1:0] PSRC_SUPPLY  = 2'h0;
  localparam logic [1:0] PSRC_EXT_REF = 2'h1;
  localparam logic [1:0] PSRC_FIXED   = 2'h2;
  // reference settling time
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS     = 25000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : vref_dac_pkg

// ### logic/settle_counter.sv
// settle counter: counts cycles from enable, restarts on disable, flags expiry
`timescale 1ns/1ps
module settle_counter #(
  parameter int CYCLES = 2500
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  output logic      done_o
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] count_reg; // cycles since enable

  // count while running, clear on every drop of run
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= '0;
      done_o    <= 1'b0;
    end else if (!run_i) begin
      count_reg <= '0;
      done_o    <= 1'b0;
    end else if (!done_o) begin
      if (count_reg == LAST) begin
        done_o <= 1'b1;
      end
      count_reg <= count_reg + 1'b1;
    end
  end
endmodule : settle_counter

// ### logic/vref_dac_control.sv
// top: register file and control outputs of the fixed reference and the ladder converter
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module vref_dac_control #(
  parameter int SETTLE_CYCLES = vref_dac_pkg::SETTLE_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // register port
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // sleep and pin
  input  wire logic       sleep_i,         // device in sleep; no effect on registers
  input  wire logic       pin_digital_i,   // raw digital level of the output pin
  output logic            pin_digital_o,   // synchronised pin level as digital readers see it
  // analog controls
  output logic            ref_power_o,
  output logic      [1:0] ref_gain_o,
  output logic            ref_comparator_buffer_on_o,
  output logic            ref_adc_buffer_on_o,
  output logic            ladder_enable_o,
  output logic      [4:0] ladder_level_code_o,
  output logic            pos_source_connect_o,
  output logic            neg_source_connect_o,
  output logic      [2:0] pos_source_onehot_o, // supply, external, fixed buffer
  output logic            neg_source_ext_o,
  output logic            pin_analog_drive_o,
  output logic            pin_digital_override_o,
  output logic            irq_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic       ref_en_reg;      // ref_power_enable
  logic [1:0] gain_reg;        // ref_gain_select
  logic [7:0] src_reg;         // dac_source_control writable bits
  logic [4:0] level_reg;       // ladder_level_code
  logic [7:0] adc_cfg_reg;     // adc_on, positive ref config, channel select
  logic [vref_dac_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [vref_dac_pkg::IRQ_W-1:0] irq_mask_reg;
  logic       ref_en_next;     // enable as it stands after this edge
  logic       ready;           // from settle counter
  logic [vref_dac_pkg::IRQ_W-1:0] irq_set;  // ready rose or fell this cycle
  logic [vref_dac_pkg::IRQ_W-1:0] irq_clr;  // written ones on the status address
  logic [vref_dac_pkg::IRQ_W-1:0] irq_next; // status after this edge
  logic       ready_d_reg;     // previous ready for edge events
  logic       pin_sync1_reg;   // synchroniser stage one
  logic       pin_sync2_reg;   // synchroniser stage two

  // write decode helper
  function automatic logic hit(input logic [2:0] a, input logic [2:0] target, input logic s);
    hit = s && (a == target);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////////
  // reference control register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_en_reg <= 1'b0;
      gain_reg   <= vref_dac_pkg::REF_CTRL_RESET[vref_dac_pkg::GAIN_HI:vref_dac_pkg::GAIN_LO];
    end else if (hit(addr_i, vref_dac_pkg::ADDR_REF_CTRL, wr_i)) begin
      ref_en_reg <= wdata_i[vref_dac_pkg::REF_EN_BIT];
      gain_reg   <= wdata_i[vref_dac_pkg::GAIN_HI:vref_dac_pkg::GAIN_LO];
    end
  end

  // enable as it will stand after this edge; the settle counter follows it,
  // so ready falls in the same cycle as the enable instead of one cycle late
  always_comb begin
    ref_en_next = ref_en_reg;
    if (hit(addr_i, vref_dac_pkg::ADDR_REF_CTRL, wr_i)) begin
      ref_en_next = wdata_i[vref_dac_pkg::REF_EN_BIT];
    end
  end

  // converter source and level registers; sleep is ignored so contents survive wake
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_reg   <= 8'h00;
      level_reg <= 5'h00;
    end else begin
      if (hit(addr_i, vref_dac_pkg::ADDR_SRC_CTRL, wr_i)) begin
        src_reg <= wdata_i & vref_dac_pkg::SRC_CTRL_WMASK;
      end
      if (hit(addr_i, vref_dac_pkg::ADDR_LEVEL_SEL, wr_i)) begin
        level_reg <= wdata_i[vref_dac_pkg::LEVEL_W-1:0];
      end
    end
  end

  // adc-side state mirror written by software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adc_cfg_reg <= 8'h00;
    end else if (hit(addr_i, vref_dac_pkg::ADDR_ADC_CFG, wr_i)) begin
      adc_cfg_reg <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // settling of the reference
  settle_counter #(
    .CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (ref_en_next),
    .done_o  (ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over the write-one clear
  // ready edges raise the two events
  always_comb begin
    irq_set                              = '0;
    irq_set[vref_dac_pkg::IRQ_READY_BIT] = ready & ~ready_d_reg;
    irq_set[vref_dac_pkg::IRQ_LOST_BIT]  = ~ready & ready_d_reg;
  end

  // per status bit: a written one clears, an event in the same cycle still sets
  for (genvar b = 0; b < vref_dac_pkg::IRQ_W; b++) begin : g_irq_bit
    assign irq_clr[b]  = hit(addr_i, vref_dac_pkg::ADDR_IRQ_STATUS, wr_i) & wdata_i[b];
    assign irq_next[b] = (irq_stat_reg[b] & ~irq_clr[b]) | irq_set[b];
  end

  // status, mask and level output; a new mask acts one cycle after its write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      ready_d_reg  <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      ready_d_reg  <= ready;
      irq_stat_reg <= irq_next;
      if (hit(addr_i, vref_dac_pkg::ADDR_IRQ_MASK, wr_i)) begin
        irq_mask_reg <= wdata_i[vref_dac_pkg::IRQ_W-1:0];
      end
      irq_o <= |(irq_next & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read: data in the cycle after the strobe only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        vref_dac_pkg::ADDR_REF_CTRL:   rdata_o <= {ref_en_reg, ready, gain_reg, 4'h0};
        vref_dac_pkg::ADDR_SRC_CTRL:   rdata_o <= src_reg;
        vref_dac_pkg::ADDR_LEVEL_SEL:  rdata_o <= {3'h0, level_reg};
        vref_dac_pkg::ADDR_IRQ_STATUS: rdata_o <= {{(8-vref_dac_pkg::IRQ_W){1'b0}}, irq_stat_reg};
        vref_dac_pkg::ADDR_IRQ_MASK:   rdata_o <= {{(8-vref_dac_pkg::IRQ_W){1'b0}}, irq_mask_reg};
        vref_dac_pkg::ADDR_ADC_CFG:    rdata_o <= adc_cfg_reg;
        default:                       rdata_o <= 8'h00; // unmapped reads zero
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser and digital read override
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sync1_reg <= 1'b0;
      pin_sync2_reg <= 1'b0;
      pin_digital_o <= 1'b0;
    end else begin
      pin_sync1_reg <= pin_digital_i;
      pin_sync2_reg <= pin_sync1_reg;
      pin_digital_o <= pin_sync2_reg & ~src_reg[vref_dac_pkg::PIN_OE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered analog control outputs, one cycle behind the register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_power_o                <= 1'b0;
      ref_gain_o                 <= vref_dac_pkg::GAIN_OFF;
      ref_comparator_buffer_on_o <= 1'b0;
      ref_adc_buffer_on_o        <= 1'b0;
      ladder_enable_o            <= 1'b0;
      ladder_level_code_o        <= 5'h00;
      pos_source_connect_o       <= 1'b0;
      neg_source_connect_o       <= 1'b0;
      pos_source_onehot_o        <= 3'h0;
      neg_source_ext_o           <= 1'b0;
      pin_analog_drive_o         <= 1'b0;
      pin_digital_override_o     <= 1'b0;
    end else begin
      ref_power_o                <= ref_en_reg;
      ref_gain_o                 <= gain_reg;
      ref_comparator_buffer_on_o <= ref_en_reg && (gain_reg != vref_dac_pkg::GAIN_OFF);
      ref_adc_buffer_on_o        <= adc_cfg_reg[vref_dac_pkg::ADC_ON_BIT] &&
        ((adc_cfg_reg[vref_dac_pkg::PVCFG_HI:vref_dac_pkg::PVCFG_LO] == vref_dac_pkg::PVCFG_FIXED_REF) ||
         (adc_cfg_reg[4:0] == vref_dac_pkg::CHAN_FIXED_REF));
      ladder_enable_o            <= src_reg[vref_dac_pkg::CONV_EN_BIT];
      ladder_level_code_o        <= level_reg;
      pos_source_connect_o       <= src_reg[vref_dac_pkg::LOW_PWR_BIT] | src_reg[vref_dac_pkg::CONV_EN_BIT];
      neg_source_connect_o       <= ~src_reg[vref_dac_pkg::LOW_PWR_BIT] | src_reg[vref_dac_pkg::CONV_EN_BIT];
      case (src_reg[vref_dac_pkg::POS_SRC_HI:vref_dac_pkg::POS_SRC_LO])
        vref_dac_pkg::PSRC_SUPPLY:  pos_source_onehot_o <= 3'h1;
        vref_dac_pkg::PSRC_EXT_REF: pos_source_onehot_o <= 3'h2;
        vref_dac_pkg::PSRC_FIXED:   pos_source_onehot_o <= 3'h4;
        default:                    pos_source_onehot_o <= 3'h0; // reserved code connects nothing
      endcase
      neg_source_ext_o           <= src_reg[vref_dac_pkg::NEG_SRC_BIT];
      pin_analog_drive_o         <= src_reg[vref_dac_pkg::PIN_OE_BIT];
      pin_digital_override_o     <= src_reg[vref_dac_pkg::PIN_OE_BIT];
    end
  end
  // clamp sequences need only the low-power source logic above

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_ref_power;
    @(posedge clk_i) disable iff (!rst_n_i) ref_power_o == $past(ref_en_reg);
  endproperty
  a_ref_power: assert property (p_ref_power) else $error("reference power mismatch");

  property p_ready_low;
    @(posedge clk_i) disable iff (!rst_n_i) !ref_en_reg |-> !ready;
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready while disabled");

  property p_gain_off;
    @(posedge clk_i) disable iff (!rst_n_i) (gain_reg == vref_dac_pkg::GAIN_OFF) |=> !ref_comparator_buffer_on_o;
  endproperty
  a_gain_off: assert property (p_gain_off) else $error("buffer on with gain off");

  property p_adc_buf;
    @(posedge clk_i) disable iff (!rst_n_i) !adc_cfg_reg[vref_dac_pkg::ADC_ON_BIT] |=> !ref_adc_buffer_on_o;
  endproperty
  a_adc_buf: assert property (p_adc_buf) else $error("adc buffer on while adc off");

  property p_ref_low_bits;
    @(posedge clk_i) disable iff (!rst_n_i) (rd_i && addr_i == vref_dac_pkg::ADDR_REF_CTRL) |=> rdata_o[3:0] == 4'h0;
  endproperty
  a_ref_low_bits: assert property (p_ref_low_bits) else $error("reference low bits not zero");

  property p_ladder_en;
    @(posedge clk_i) disable iff (!rst_n_i) ladder_enable_o == $past(src_reg[vref_dac_pkg::CONV_EN_BIT]);
  endproperty
  a_ladder_en: assert property (p_ladder_en) else $error("ladder enable mismatch");

  property p_low_power;
    @(posedge clk_i) disable iff (!rst_n_i)
      !src_reg[vref_dac_pkg::CONV_EN_BIT] |=> (pos_source_connect_o != neg_source_connect_o);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low-power source not disconnected");

  property p_pin_read;
    @(posedge clk_i) disable iff (!rst_n_i) src_reg[vref_dac_pkg::PIN_OE_BIT] |=> !pin_digital_o;
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("analog pin read not zero");

  property p_src_bits;
    @(posedge clk_i) disable iff (!rst_n_i)
      (rd_i && addr_i == vref_dac_pkg::ADDR_SRC_CTRL) |=> (rdata_o[4] == 1'b0 && rdata_o[1] == 1'b0);
  endproperty
  a_src_bits: assert property (p_src_bits) else $error("unimplemented source bits set");

  property p_settle;
    @(posedge clk_i) disable iff (!rst_n_i) $rose(ready) |-> $past(ref_en_reg, 2);
  endproperty
  a_settle: assert property (p_settle) else $error("ready without settling");

  property p_ready_flag;
    @(posedge clk_i) disable iff (!rst_n_i)
      (rd_i && addr_i == vref_dac_pkg::ADDR_REF_CTRL && !ref_en_reg) |=> !rdata_o[vref_dac_pkg::REF_READY_BIT];
  endproperty
  a_ready_flag: assert property (p_ready_flag) else $error("ready flag read while disabled");

  property p_cmp_buf_on;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ref_en_reg && gain_reg != vref_dac_pkg::GAIN_OFF) |=> ref_comparator_buffer_on_o;
  endproperty
  a_cmp_buf_on: assert property (p_cmp_buf_on) else $error("buffer off with gain on");

  property p_level_out;
    @(posedge clk_i) disable iff (!rst_n_i) ladder_level_code_o == $past(level_reg);
  endproperty
  a_level_out: assert property (p_level_out) else $error("level code mismatch");

  property p_pin_drive;
    @(posedge clk_i) disable iff (!rst_n_i)
      pin_analog_drive_o == $past(src_reg[vref_dac_pkg::PIN_OE_BIT]) && pin_digital_override_o == pin_analog_drive_o;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin drive mismatch");

  property p_pos_src;
    @(posedge clk_i) disable iff (!rst_n_i)
      !(&src_reg[vref_dac_pkg::POS_SRC_HI:vref_dac_pkg::POS_SRC_LO]) |=> $onehot(pos_source_onehot_o);
  endproperty
  a_pos_src: assert property (p_pos_src) else $error("positive source not one-hot");

  property p_neg_src;
    @(posedge clk_i) disable iff (!rst_n_i) neg_source_ext_o == $past(src_reg[vref_dac_pkg::NEG_SRC_BIT]);
  endproperty
  a_neg_src: assert property (p_neg_src) else $error("negative source mismatch");

  property p_sleep_keep;
    @(posedge clk_i) disable iff (!rst_n_i)
      (sleep_i && !hit(addr_i, vref_dac_pkg::ADDR_SRC_CTRL, wr_i)) |=> $stable(src_reg);
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) else $error("source register changed in sleep");

  property p_reset_clear;
    @(posedge clk_i)
      $rose(rst_n_i) |-> (!ladder_enable_o && !pin_analog_drive_o && ladder_level_code_o == 5'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("converter not cleared by reset");

  property p_irq_idle;
    @(posedge clk_i) disable iff (!rst_n_i) (irq_stat_reg == '0) |-> !irq_o;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("interrupt without status");

  property p_irq_set_wins;
    @(posedge clk_i) disable iff (!rst_n_i)
      (irq_set != '0) |=> ((irq_stat_reg & $past(irq_set)) == $past(irq_set));
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("event lost to clear");
endmodule : vref_dac_control

// ### verif/vref_dac_control_tb.sv
// testbench: register-port scenarios for the reference and ladder control block
`timescale 1ns/1ps
module vref_dac_control_tb;
  localparam int SETTLE = 8;     // shortened settle count keeps the run brief
  logic       clk_i;             // 100 mhz clock
  logic       rst_n_i;           // asynchronous reset, active low
  logic [2:0] addr_i;            // register index
  logic [7:0] wdata_i;           // write data
  logic       wr_i;              // write strobe
  logic       rd_i;              // read strobe
  logic       sleep_i;           // sleep level
  logic       pin_digital_i;     // raw pin level
  logic [7:0] rdata_o;           // read data
  logic       pin_digital_o;     // pin level seen by digital readers
  logic       ref_power_o;       // reference powered
  logic [1:0] ref_gain_o;        // reference gain
  logic       cmp_buf;           // comparator-side buffer on
  logic       adc_buf;           // adc-side buffer on
  logic       lad_en;            // ladder enabled
  logic [4:0] level_code;        // ladder tap
  logic       pos_con;           // positive source connected
  logic       neg_con;           // negative source connected
  logic [2:0] pos_onehot;        // positive source choice
  logic       neg_ext;           // external negative source
  logic       pin_drv;           // analog drive onto pin
  logic       pin_ovr;           // digital pin functions overridden
  logic       irq_o;             // interrupt level
  logic [7:0] rd_val;            // last value read back
  int         err_count;         // mismatches
  int         n_compared;        // comparisons made

  ////////////////////////////////////////////////////////////////////////////////
  // device under test, short settle count
  vref_dac_control #(.SETTLE_CYCLES(SETTLE)) i_vref_dac_control (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sleep_i(sleep_i), .pin_digital_i(pin_digital_i), .pin_digital_o(pin_digital_o),
    .ref_power_o(ref_power_o), .ref_gain_o(ref_gain_o), .ref_comparator_buffer_on_o(cmp_buf),
    .ref_adc_buffer_on_o(adc_buf), .ladder_enable_o(lad_en), .ladder_level_code_o(level_code),
    .pos_source_connect_o(pos_con), .neg_source_connect_o(neg_con), .pos_source_onehot_o(pos_onehot),
    .neg_source_ext_o(neg_ext), .pin_analog_drive_o(pin_drv), .pin_digital_override_o(pin_ovr),
    .irq_o(irq_o));

  // free-running clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare one byte; narrower results are zero-extended by the caller
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // one-cycle write; the strobe drops at the taking edge so re-entry never collides
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // one-cycle read; data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 rd_val = rdata_o;
  endtask : rd

  // outputs follow a register one cycle later
  task automatic settle;
    @(posedge clk_i);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  // every gain code from a cold reference; ready must still be low
  task automatic t_ref;
    for (int g = 0; g < 4; g++) begin
      wr(vref_dac_pkg::ADDR_REF_CTRL, {2'h3, g[1:0], 4'h3});
      rd(vref_dac_pkg::ADDR_REF_CTRL);
      check("ref ctrl", rd_val, {2'h2, g[1:0], 4'h0});
      check("ref outs", {4'h0, ref_power_o, cmp_buf, ref_gain_o}, {4'h0, 1'b1, g != 0, g[1:0]});
      wr(vref_dac_pkg::ADDR_REF_CTRL, 8'h00);
      settle;
      check("ref off", {7'h0, ref_power_o}, 8'h00);
    end
    $display("test ref done");
  endtask : t_ref

  // settle count, ready event, mask and write-one-to-clear, then loss of ready
  task automatic t_ready;
    int n;
    wr(vref_dac_pkg::ADDR_REF_CTRL, 8'h90);
    n = 0;
    do begin
      rd(vref_dac_pkg::ADDR_REF_CTRL);
      n++;
    end while (rd_val[6] !== 1'b1 && n < 40);
    if (rd_val[6] !== 1'b1) begin
      err_count++;
      tally_and_finish;
    end
    check("settle reads", {7'h0, n >= SETTLE / 2 && n <= SETTLE / 2 + 2}, 8'h01);
    rd(vref_dac_pkg::ADDR_IRQ_STATUS);
    check("status", rd_val, 8'h01);
    check("irq masked", {7'h0, irq_o}, 8'h00);
    wr(vref_dac_pkg::ADDR_IRQ_MASK, 8'h03);
    settle;
    check("irq", {7'h0, irq_o}, 8'h01);
    wr(vref_dac_pkg::ADDR_IRQ_STATUS, 8'h01);
    settle;
    check("irq clr", {7'h0, irq_o}, 8'h00);
    wr(vref_dac_pkg::ADDR_REF_CTRL, 8'h10);
    rd(vref_dac_pkg::ADDR_REF_CTRL);
    check("not ready", rd_val, 8'h10);
    rd(vref_dac_pkg::ADDR_IRQ_STATUS);
    check("lost", rd_val, 8'h02);
    wr(vref_dac_pkg::ADDR_IRQ_STATUS, 8'h02);
    $display("test ready done");
  endtask : t_ready

  // adc-side buffer only when the adc is on and uses the reference
  task automatic t_adc;
    logic [7:0] cfg[6] = '{8'h00, 8'hc0, 8'h9f, 8'h40, 8'h1f, 8'hbe};
    logic       exp[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++) begin
      wr(vref_dac_pkg::ADDR_ADC_CFG, cfg[i]);
      settle;
      check("adc buffer", {7'h0, adc_buf}, {7'h0, exp[i]});
    end
    $display("test adc done");
  endtask : t_adc

  // positive source codes with converter, pin and negative bits set
  task automatic t_src;
    for (int p = 0; p < 3; p++) begin
      wr(vref_dac_pkg::ADDR_SRC_CTRL, {4'hf, p[1:0], 2'h3});
      rd(vref_dac_pkg::ADDR_SRC_CTRL);
      check("src ctrl", rd_val, {4'he, p[1:0], 2'h1});
      check("src outs", {lad_en, pos_con, neg_con, pin_drv, pin_ovr, pos_onehot}, {5'h1f, 3'(1 << p)});
      check("neg ext", {7'h0, neg_ext}, 8'h01);
    end
    $display("test src done");
  endtask : t_src

  // both minimum-power clamp sequences
  task automatic t_clamp;
    logic [7:0] src[2] = '{8'h40, 8'h01};
    logic [7:0] lvl[2] = '{8'h1f, 8'h00};
    logic [7:0] exp[2] = '{8'h41, 8'h21};
    for (int i = 0; i < 2; i++) begin
      wr(vref_dac_pkg::ADDR_SRC_CTRL, src[i]);
      wr(vref_dac_pkg::ADDR_LEVEL_SEL, lvl[i]);
      settle;
      check("clamp outs", {lad_en, pos_con, neg_con, pin_drv, pin_ovr, pos_onehot}, exp[i]);
      check("clamp level", {3'h0, level_code}, lvl[i]);
      check("clamp neg", {7'h0, neg_ext}, {7'h0, src[i][0]});
    end
    $display("test clamp done");
  endtask : t_clamp

  // level code takes the low five bits only
  task automatic t_level;
    logic [7:0] v[2] = '{8'hff, 8'hea};
    for (int i = 0; i < 2; i++) begin
      wr(vref_dac_pkg::ADDR_LEVEL_SEL, v[i]);
      rd(vref_dac_pkg::ADDR_LEVEL_SEL);
      check("level reg", rd_val, {3'h0, v[i][4:0]});
      check("level out", {3'h0, level_code}, {3'h0, v[i][4:0]});
    end
    $display("test level done");
  endtask : t_level

  // digital reads of the pin are forced low while it carries the analog level
  task automatic t_pin;
    wr(vref_dac_pkg::ADDR_SRC_CTRL, 8'h00);
    pin_digital_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 check("pin read", {7'h0, pin_digital_o}, 8'h01);
    wr(vref_dac_pkg::ADDR_SRC_CTRL, 8'h20);
    repeat (4) @(posedge clk_i);
    #1 check("pin analog", {6'h0, pin_digital_o, pin_ovr}, 8'h01);
    $display("test pin done");
  endtask : t_pin

  // sleep leaves the source register alone; unmapped place reads zero
  task automatic t_sleep;
    wr(vref_dac_pkg::ADDR_REF_CTRL, 8'h10);
    wr(vref_dac_pkg::ADDR_SRC_CTRL, 8'h89);
    sleep_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    sleep_i <= 1'b0;
    rd(vref_dac_pkg::ADDR_SRC_CTRL);
    check("after sleep", rd_val, 8'h89);
    check("ref off in sleep", {7'h0, ref_power_o}, 8'h00);
    wr(3'h7, 8'hff);
    rd(3'h7);
    check("unmapped", rd_val, 8'h00);
    $display("test sleep done");
  endtask : t_sleep

  // reset in mid-run clears ladder, pin drive and level code
  task automatic t_reset;
    wr(vref_dac_pkg::ADDR_SRC_CTRL, 8'ha0);
    wr(vref_dac_pkg::ADDR_LEVEL_SEL, 8'h1f);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 check("in reset", {lad_en, pin_drv, 1'b0, level_code}, 8'h00);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(vref_dac_pkg::ADDR_SRC_CTRL);
    check("src reset", rd_val, 8'h00);
    rd(vref_dac_pkg::ADDR_LEVEL_SEL);
    check("level reset", rd_val, 8'h00);
    rd(vref_dac_pkg::ADDR_REF_CTRL);
    check("ref reset", rd_val, vref_dac_pkg::REF_CTRL_RESET);
    $display("test reset done");
  endtask : t_reset

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    err_count     = 0;
    n_compared    = 0;
    rst_n_i       = 1'b0;
    addr_i        = 3'h0;
    wdata_i       = 8'h00;
    wr_i          = 1'b0;
    rd_i          = 1'b0;
    sleep_i       = 1'b0;
    pin_digital_i = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_ref;
    t_ready;
    t_adc;
    t_src;
    t_clamp;
    t_level;
    t_pin;
    t_sleep;
    t_reset;
    tally_and_finish;
  end
endmodule : vref_dac_control_tb
